// [inc/ioxm_consts.svh]
// Purpose: constants for the expander manager
// Assumes: core clock 25 MHz
// Notes: expander register numbers, group bounds and timing
`ifndef IOXM_CONSTS_SVH
`define IOXM_CONSTS_SVH
`define IOXM_CLK_HZ 25000000
`define IOXM_UPDATE_MS 40
`define IOXM_UPDATE_CYC ((`IOXM_CLK_HZ / 1000) * `IOXM_UPDATE_MS)
`define IOXM_NUM_EXP 14
`define IOXM_REG_IN0 8'h00
`define IOXM_REG_IN1 8'h01
`define IOXM_REG_OUT0 8'h02
`define IOXM_REG_OUT1 8'h03
`define IOXM_REG_POL0 8'h04
`define IOXM_REG_POL1 8'h05
`define IOXM_REG_CFG0 8'h06
`define IOXM_REG_CFG1 8'h07
`define IOXM_POL_NONE 8'h00
`define IOXM_CFG_ALL_IN 8'hff
`define IOXM_CFG_ALL_OUT 8'h00
`define IOXM_EXP_MRL 4'h8
`define IOXM_EXP_FRST 4'hb
`define IOXM_EXP_LINKUP 4'hc
`define IOXM_EXP_LINKACT 4'hd
`endif

// [inc/ioxm_pkg.sv]
// Purpose: types for the expander manager
// Assumes: nothing
// Notes: step sequencer states, one-hot
package ioxm_pkg;
    typedef enum logic [5:0] {
        IOXM_IDLE = 6'h01,
        IOXM_ISSUE = 6'h02,
        IOXM_WAIT = 6'h04,
        IOXM_NEXT = 6'h08,
        IOXM_SCAN = 6'h10,
        IOXM_DONE = 6'h20
    } ioxm_state_t;
    typedef enum logic [1:0] {
        IOXM_KIND_CFG = 2'h0,
        IOXM_KIND_UPD = 2'h1,
        IOXM_KIND_RD = 2'h2
    } ioxm_kind_t;
endpackage : ioxm_pkg

// [rtl/ioxm_manager.sv]
// Purpose: serves 14 SMBus expanders: configure, update outputs, read inputs
// Assumes: an SMBus master engine on the link clock executes one-register jobs
// Notes: expanders 8/11 input-only, 12/13 output-only, others mixed
`timescale 1ns/10ps
`include "ioxm_consts.svh"
module ioxm_manager #(
    parameter int NUM_EXP = `IOXM_NUM_EXP,
    parameter int UPDATE_CYC = `IOXM_UPDATE_CYC
) (
    // core clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic fundResetActive,
    // link-side clock of the SMBus engine
    input wire logic linkClk,
    input wire logic linkRst,
    // configuration state
    input wire logic eepromInitDone,
    input wire logic [NUM_EXP-1:0] expanderEnable,
    input wire logic [NUM_EXP-1:0] expander_address_field_wr,
    // internal view of expander outputs, 16 bits per expander
    input wire logic [16*NUM_EXP-1:0] outputView,
    input wire logic [16*NUM_EXP-1:0] dirInputMask,
    // shared interrupt from the board, active low
    input wire logic shared_expander_irq_n,
    // single-register job to the link-side engine
    output logic jobReq_reg,
    output logic [3:0] jobExp_reg,
    output logic jobRead_reg,
    output logic [7:0] jobRegNum_reg,
    output logic [7:0] jobData_reg,
    input wire logic jobDone,
    input wire logic jobError,
    input wire logic [7:0] jobRdData,
    // results
    output logic [16*NUM_EXP-1:0] inputState_reg,
    output logic [3:0] master_serial_status_reg
);
    ////////////////////////////////////////////////////////////////////////
    // interrupt synchroniser, three flops, change once 2nd and 3rd agree
    logic [2:0] irqSync_reg;
    logic irqAsserted_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqSync_reg <= 3'h7;
        end else begin
            irqSync_reg <= {irqSync_reg[1:0], shared_expander_irq_n};
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqAsserted_reg <= 1'b0;
        end else if (irqSync_reg[2] == irqSync_reg[1]) begin
            irqAsserted_reg <= ~irqSync_reg[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link handshake: toggle request/ack crossing, job words held stable
    logic reqTog_reg;
    logic [2:0] ackSync_reg;
    logic linkReqS1_reg;
    logic linkReqS2_reg;
    logic linkReqS3_reg;
    logic linkAckTog_reg;
    logic linkErr_reg;
    logic [7:0] linkRd_reg;
    logic linkBusy_reg;
    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            linkReqS1_reg <= 1'b0;
            linkReqS2_reg <= 1'b0;
            linkReqS3_reg <= 1'b0;
        end else begin
            linkReqS1_reg <= reqTog_reg;
            linkReqS2_reg <= linkReqS1_reg;
            linkReqS3_reg <= linkReqS2_reg;
        end
    end
    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            linkBusy_reg <= 1'b0;
            linkAckTog_reg <= 1'b0;
            linkErr_reg <= 1'b0;
            linkRd_reg <= 8'h00;
        end else if (!linkBusy_reg && (linkReqS3_reg != linkAckTog_reg)) begin
            linkBusy_reg <= 1'b1;
        end else if (linkBusy_reg && jobDone) begin
            linkBusy_reg <= 1'b0;
            linkErr_reg <= jobError;
            linkRd_reg <= jobRdData;
            linkAckTog_reg <= ~linkAckTog_reg;
        end
    end
    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            jobReq_reg <= 1'b0;
        end else begin
            jobReq_reg <= linkBusy_reg && !jobDone;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ackSync_reg <= 3'h0;
        end else begin
            ackSync_reg <= {ackSync_reg[1:0], linkAckTog_reg};
        end
    end
    logic ackSeen_reg;
    logic jobBack;
    assign jobBack = (ackSync_reg[2] == ackSync_reg[1]) && (ackSync_reg[2] != ackSeen_reg);

    ////////////////////////////////////////////////////////////////////////
    // per-expander pending work and update-period timers
    logic [NUM_EXP-1:0] cfgPend_reg;
    logic [NUM_EXP-1:0] rdPend_reg;
    logic [NUM_EXP-1:0] written_reg;
    logic [16*NUM_EXP-1:0] lastWritten_reg;
    logic [31:0] updTimer_reg [NUM_EXP];
    logic [31:0] rdTimer_reg;
    logic [NUM_EXP-1:0] isInOnly;
    logic [NUM_EXP-1:0] isOutOnly;
    logic [NUM_EXP-1:0] updNeed;
    logic normalOp;
    assign normalOp = eepromInitDone && !fundResetActive;

    always_comb begin
        isInOnly = '0;
        isOutOnly = '0;
        isInOnly[`IOXM_EXP_MRL] = 1'b1;
        isInOnly[`IOXM_EXP_FRST] = 1'b1;
        isOutOnly[`IOXM_EXP_LINKUP] = 1'b1;
        isOutOnly[`IOXM_EXP_LINKACT] = 1'b1;
    end
    // any mismatch between view and last written value on an enabled, configured,
    // not input-only expander, whatever caused it (hot reset, bus reset, software), calls for a write
    always_comb begin
        for (int i = 0; i < NUM_EXP; i++) begin
            updNeed[i] = expanderEnable[i] && written_reg[i] && !isInOnly[i]
                && (outputView[16*i +: 16] != lastWritten_reg[16*i +: 16]);
        end
    end

    ioxm_pkg::ioxm_state_t state_reg;
    ioxm_pkg::ioxm_kind_t kind_reg;
    logic [3:0] cur_reg;
    logic [2:0] step_reg;
    logic [2:0] lastStep;
    logic [7:0] stepReg;
    logic stepRead;
    logic [7:0] stepData;
    logic [15:0] curView;
    assign curView = outputView[16*cur_reg +: 16];

    // step table: cfg runs out-regs except on input-only expanders, pol, dir, then input reads except on output-only expanders
    always_comb begin
        stepRead = 1'b0;
        stepData = `IOXM_POL_NONE;
        stepReg = `IOXM_REG_OUT0;
        lastStep = 3'h0;
        unique case (kind_reg)
            ioxm_pkg::IOXM_KIND_CFG: begin
                lastStep = isOutOnly[cur_reg] ? 3'h5 : 3'h7;
                unique case (step_reg)
                    3'h0: begin
                        stepReg = `IOXM_REG_OUT0;
                        stepData = curView[7:0];
                    end
                    3'h1: begin
                        stepReg = `IOXM_REG_OUT1;
                        stepData = curView[15:8];
                    end
                    3'h2: stepReg = `IOXM_REG_POL0;
                    3'h3: stepReg = `IOXM_REG_POL1;
                    3'h4: begin
                        stepReg = `IOXM_REG_CFG0;
                        stepData = isInOnly[cur_reg] ? `IOXM_CFG_ALL_IN :
                            isOutOnly[cur_reg] ? `IOXM_CFG_ALL_OUT :
                            dirInputMask[16*cur_reg +: 8];
                    end
                    3'h5: begin
                        stepReg = `IOXM_REG_CFG1;
                        stepData = isInOnly[cur_reg] ? `IOXM_CFG_ALL_IN :
                            isOutOnly[cur_reg] ? `IOXM_CFG_ALL_OUT :
                            dirInputMask[16*cur_reg+8 +: 8];
                    end
                    3'h6: begin
                        stepReg = `IOXM_REG_IN0;
                        stepRead = 1'b1;
                    end
                    default: begin
                        stepReg = `IOXM_REG_IN1;
                        stepRead = 1'b1;
                    end
                endcase
            end
            ioxm_pkg::IOXM_KIND_UPD: begin
                lastStep = 3'h1;
                stepReg = step_reg[0] ? `IOXM_REG_OUT1 : `IOXM_REG_OUT0;
                stepData = step_reg[0] ? curView[15:8] : curView[7:0];
            end
            default: begin
                lastStep = 3'h1;
                stepReg = step_reg[0] ? `IOXM_REG_IN1 : `IOXM_REG_IN0;
                stepRead = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: round-robin scan from the expander after the last served
    logic [3:0] scanIdx_reg;
    logic [3:0] scanCnt_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ioxm_pkg::IOXM_IDLE;
            kind_reg <= ioxm_pkg::IOXM_KIND_CFG;
            cur_reg <= 4'h0;
            step_reg <= 3'h0;
            scanIdx_reg <= 4'h0;
            scanCnt_reg <= 4'h0;
            reqTog_reg <= 1'b0;
            ackSeen_reg <= 1'b0;
            jobExp_reg <= 4'h0;
            jobRead_reg <= 1'b0;
            jobRegNum_reg <= 8'h00;
            jobData_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                ioxm_pkg::IOXM_IDLE: begin
                    // in fundamental reset no new sequence starts, so outputs stay once a running one ends
                    if (normalOp) begin
                        scanCnt_reg <= 4'h0;
                        state_reg <= ioxm_pkg::IOXM_SCAN;
                    end
                end
                ioxm_pkg::IOXM_SCAN: begin
                    if (!normalOp) begin
                        state_reg <= ioxm_pkg::IOXM_IDLE;
                    end else if (expanderEnable[scanIdx_reg] && cfgPend_reg[scanIdx_reg]) begin
                        kind_reg <= ioxm_pkg::IOXM_KIND_CFG;
                        state_reg <= ioxm_pkg::IOXM_ISSUE;
                    end else if (updNeed[scanIdx_reg] && updTimer_reg[scanIdx_reg] == 32'h0) begin
                        kind_reg <= ioxm_pkg::IOXM_KIND_UPD;
                        state_reg <= ioxm_pkg::IOXM_ISSUE;
                    end else if (expanderEnable[scanIdx_reg] && rdPend_reg[scanIdx_reg]
                        && !isOutOnly[scanIdx_reg]) begin
                        kind_reg <= ioxm_pkg::IOXM_KIND_RD;
                        state_reg <= ioxm_pkg::IOXM_ISSUE;
                    end else begin
                        scanCnt_reg <= scanCnt_reg + 4'h1;
                        if (scanCnt_reg == 4'(NUM_EXP - 1)) begin
                            state_reg <= ioxm_pkg::IOXM_IDLE;
                        end
                    end
                    if (state_reg == ioxm_pkg::IOXM_SCAN) begin
                        cur_reg <= scanIdx_reg;
                        step_reg <= {1'b0, isInOnly[scanIdx_reg] & cfgPend_reg[scanIdx_reg], 1'b0};
                        scanIdx_reg <= (scanIdx_reg == 4'(NUM_EXP - 1)) ? 4'h0
                            : scanIdx_reg + 4'h1;
                    end
                end
                ioxm_pkg::IOXM_ISSUE: begin
                    jobExp_reg <= cur_reg;
                    jobRead_reg <= stepRead;
                    jobRegNum_reg <= stepReg;
                    jobData_reg <= stepData;
                    reqTog_reg <= ~reqTog_reg;
                    state_reg <= ioxm_pkg::IOXM_WAIT;
                end
                ioxm_pkg::IOXM_WAIT: begin
                    if (jobBack) begin
                        ackSeen_reg <= ackSync_reg[2];
                        state_reg <= ioxm_pkg::IOXM_NEXT;
                    end
                end
                ioxm_pkg::IOXM_NEXT: begin
                    step_reg <= step_reg + 3'h1;
                    state_reg <= (step_reg == lastStep) ? ioxm_pkg::IOXM_DONE
                        : ioxm_pkg::IOXM_ISSUE;
                end
                ioxm_pkg::IOXM_DONE: begin
                    scanCnt_reg <= 4'h0;
                    state_reg <= ioxm_pkg::IOXM_SCAN;
                end
                default: state_reg <= ioxm_pkg::IOXM_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bookkeeping of pending work; a new request wins over its own clear
    logic finishing;
    assign finishing = (state_reg == ioxm_pkg::IOXM_NEXT) && (step_reg == lastStep);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgPend_reg <= '1;
            written_reg <= '0;
            lastWritten_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_EXP; i++) begin
                if (finishing && cur_reg == 4'(i) && kind_reg != ioxm_pkg::IOXM_KIND_RD) begin
                    cfgPend_reg[i] <= 1'b0;
                    written_reg[i] <= 1'b1;
                end
                if (expander_address_field_wr[i]) begin
                    cfgPend_reg[i] <= 1'b1;
                end
            end
            if (state_reg == ioxm_pkg::IOXM_ISSUE && !stepRead) begin
                if (stepReg == `IOXM_REG_OUT0) begin
                    lastWritten_reg[16*cur_reg +: 8] <= stepData;
                end
                if (stepReg == `IOXM_REG_OUT1) begin
                    lastWritten_reg[16*cur_reg+8 +: 8] <= stepData;
                end
            end
        end
    end
    // one read pass at most per update period, launched by the interrupt
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdPend_reg <= '0;
            rdTimer_reg <= 32'h0;
        end else begin
            if (rdTimer_reg != 32'h0) begin
                rdTimer_reg <= rdTimer_reg - 32'h1;
            end
            for (int i = 0; i < NUM_EXP; i++) begin
                if (finishing && cur_reg == 4'(i) && !kind_reg[0]) begin
                    rdPend_reg[i] <= 1'b0;
                end
            end
            if (irqAsserted_reg && rdTimer_reg == 32'h0 && rdPend_reg == '0 && normalOp) begin
                rdPend_reg <= ~isOutOnly;
                rdTimer_reg <= 32'(UPDATE_CYC);
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_EXP; i++) begin
                updTimer_reg[i] <= 32'h0;
            end
        end else begin
            for (int i = 0; i < NUM_EXP; i++) begin
                if (finishing && cur_reg == 4'(i) && kind_reg == ioxm_pkg::IOXM_KIND_UPD) begin
                    updTimer_reg[i] <= 32'(UPDATE_CYC);
                end else if (updTimer_reg[i] != 32'h0) begin
                    updTimer_reg[i] <= updTimer_reg[i] - 32'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data capture and error status
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            inputState_reg <= '0;
            master_serial_status_reg <= 4'h0;
        end else if (state_reg == ioxm_pkg::IOXM_WAIT && jobBack) begin
            if (jobRead_reg) begin
                if (jobRegNum_reg == `IOXM_REG_IN0) begin
                    inputState_reg[16*cur_reg +: 8] <= linkRd_reg;
                end else begin
                    inputState_reg[16*cur_reg+8 +: 8] <= linkRd_reg;
                end
            end
            if (linkErr_reg) begin
                master_serial_status_reg <= {jobRead_reg, !jobRead_reg, 2'h1};
            end
        end
    end
endmodule : ioxm_manager

// [sim/ioxm_manager_props.sv]
// Purpose: port-level checks of the expander manager job stream
// Assumes: one single-register job at a time on the link side
// Notes: every check runs on the link clock, where the job words live
`timescale 1ns/10ps
module ioxm_manager_props #(
    parameter int NUM_EXP = 14,
    parameter int UPDATE_CYC = 1000000
) (
    // clocks and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic fundResetActive,
    input wire logic linkClk,
    input wire logic linkRst,
    // configuration
    input wire logic eepromInitDone,
    input wire logic [NUM_EXP-1:0] expanderEnable,
    input wire logic [NUM_EXP-1:0] expander_address_field_wr,
    input wire logic [16*NUM_EXP-1:0] outputView,
    input wire logic [16*NUM_EXP-1:0] dirInputMask,
    input wire logic shared_expander_irq_n,
    // link job
    input wire logic jobReq_reg,
    input wire logic [3:0] jobExp_reg,
    input wire logic jobRead_reg,
    input wire logic [7:0] jobRegNum_reg,
    input wire logic [7:0] jobData_reg,
    input wire logic jobDone,
    input wire logic jobError,
    input wire logic [7:0] jobRdData,
    // results
    input wire logic [16*NUM_EXP-1:0] inputState_reg,
    input wire logic [3:0] master_serial_status_reg
);
    default clocking cb @(posedge linkClk); endclocking
    default disable iff (linkRst);
    logic [3:0] prevExp;
    logic [7:0] prevReg;
    logic prevErr;
    wire wrJob = jobReq_reg && !jobRead_reg;
    // last finished job
    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            prevExp <= 4'h0;
            prevReg <= 8'h00;
            prevErr <= 1'b0;
        end else if (jobDone) begin
            prevExp <= jobExp_reg;
            prevReg <= jobRegNum_reg;
            prevErr <= jobError;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    property p_noEarly; $rose(jobReq_reg) |-> eepromInitDone; endproperty
    a_noEarly: assert property (p_noEarly) else $error("job before eeprom load done");
    property p_hold; jobReq_reg && !jobDone |=> jobReq_reg &&
        $stable({jobExp_reg, jobRead_reg, jobRegNum_reg, jobData_reg}); endproperty
    a_hold: assert property (p_hold) else $error("job words moved mid job");
    property p_drop; jobDone |=> !jobReq_reg; endproperty
    a_drop: assert property (p_drop) else $error("request held after done");
    property p_pol; wrJob && jobRegNum_reg inside {8'h04, 8'h05} |-> jobData_reg == 8'h00; endproperty
    a_pol: assert property (p_pol) else $error("polarity write not zero");
    property p_linkOut; wrJob && jobExp_reg inside {4'hc, 4'hd} &&
        jobRegNum_reg inside {8'h06, 8'h07} |-> jobData_reg == 8'h00; endproperty
    a_linkOut: assert property (p_linkOut) else $error("link expander not all output");
    property p_inOnly; wrJob && jobExp_reg inside {4'h8, 4'hb} &&
        jobRegNum_reg inside {8'h06, 8'h07} |-> jobData_reg == 8'hff; endproperty
    a_inOnly: assert property (p_inOnly) else $error("input expander not all input");
    property p_rdReg; jobReq_reg && jobRead_reg |->
        jobRegNum_reg <= 8'h01 && !(jobExp_reg inside {4'hc, 4'hd}); endproperty
    a_rdReg: assert property (p_rdReg) else $error("bad read job");
    property p_wrReg; wrJob |-> jobRegNum_reg inside {[8'h02:8'h07]}; endproperty
    a_wrReg: assert property (p_wrReg) else $error("write to input register");
    property p_order; $rose(jobReq_reg) && !prevErr && jobRegNum_reg inside {8'h01, [8'h03:8'h07]}
        && !(jobRegNum_reg == 8'h04 && jobExp_reg inside {4'h8, 4'hb})
        |-> prevExp == jobExp_reg && prevReg == jobRegNum_reg - 8'h01; endproperty
    a_order: assert property (p_order) else $error("register step out of order");
    c_err: cover property (jobDone && jobError);
    c_read8: cover property (jobDone && jobRead_reg && jobExp_reg == 4'h8);
    c_linkUp: cover property (jobDone && !jobRead_reg && jobExp_reg == 4'hc);
endmodule : ioxm_manager_props

bind ioxm_manager ioxm_manager_props #(.NUM_EXP(NUM_EXP), .UPDATE_CYC(UPDATE_CYC)) u_props (
    .clk(clk), .sys_rst(sys_rst), .fundResetActive(fundResetActive), .linkClk(linkClk),
    .linkRst(linkRst), .eepromInitDone(eepromInitDone), .expanderEnable(expanderEnable),
    .expander_address_field_wr(expander_address_field_wr), .outputView(outputView),
    .dirInputMask(dirInputMask), .shared_expander_irq_n(shared_expander_irq_n),
    .jobReq_reg(jobReq_reg), .jobExp_reg(jobExp_reg), .jobRead_reg(jobRead_reg),
    .jobRegNum_reg(jobRegNum_reg), .jobData_reg(jobData_reg), .jobDone(jobDone),
    .jobError(jobError), .jobRdData(jobRdData), .inputState_reg(inputState_reg),
    .master_serial_status_reg(master_serial_status_reg)
);

// [sim/ioxm_exp_model.sv]
// Purpose: link engine plus 14 expanders behind it
// Assumes: jobs arrive one at a time, words held until done
// Notes: read data toggles when not valid so stale values never match
`timescale 1ns/10ps
module ioxm_exp_model (
    // link job
    input wire logic linkClk,
    input wire logic jobReq,
    input wire logic [3:0] jobExp,
    input wire logic jobRead,
    input wire logic [7:0] jobRegNum,
    input wire logic [7:0] jobData,
    output logic jobDone,
    output logic jobError,
    output logic [7:0] jobRdData,
    // bench controls
    input wire logic [3:0] delayCyc,
    input wire logic failNext,
    input wire logic [223:0] pinIn,
    // wired interrupt, pulled up on the board
    output logic irqN
);
    logic [7:0] regs [14][8];
    logic [15:0] lastRead [14] = '{default: 16'h0000};
    logic [3:0] waitCnt = 4'h0;
    initial jobDone = 1'b0;
    initial jobRdData = 8'h00;
    always @(posedge linkClk) begin
        jobDone <= 1'b0;
        jobError <= 1'b0;
        jobRdData <= ~jobRdData;
        if (jobReq && !jobDone) begin
            waitCnt <= waitCnt + 4'h1;
            if (waitCnt == delayCyc) begin
                waitCnt <= 4'h0;
                jobDone <= 1'b1;
                jobError <= failNext;
                if (jobRead) begin
                    jobRdData <= pinIn[16*jobExp + 8*jobRegNum[0] +: 8];
                    lastRead[jobExp][8*jobRegNum[0] +: 8] <= pinIn[16*jobExp + 8*jobRegNum[0] +: 8];
                end else begin
                    regs[jobExp][jobRegNum[2:0]] <= jobData;
                end
            end
        end
    end
    // open drain: low while any expander with inputs (0 to 11) differs from its last read
    always_comb begin
        irqN = 1'b1;
        for (int e = 0; e < 12; e++) begin
            if (pinIn[16*e +: 16] !== lastRead[e]) begin
                irqN = 1'b0;
            end
        end
    end
endmodule : ioxm_exp_model

// [sim/ioxm_manager_test.sv]
// Purpose: scenario bench for the expander manager
// Assumes: update period shortened to 200 core cycles
// Notes: model registers are read back by hierarchy
`timescale 1ns/10ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
`define WAITC(c) for (int w = 0; w < 3000 && !(c); w++) @(posedge clk);
module ioxm_manager_test;
    localparam int UPD = 200;
    logic clk, sys_rst, linkClk, linkRst, fundResetActive, eepromInitDone, irqN, failNext;
    logic jobReq, jobRead, jobDone, jobError, prevReq;
    logic [13:0] expanderEnable, addrWr;
    logic [223:0] outputView, dirInputMask, pinIn, inputState;
    logic [3:0] jobExp, status, delayCyc;
    logic [7:0] jobRegNum, jobData, jobRdData;
    int errors = 0, nChecks = 0, nJobs = 0, cyc = 0;
    int nCfg [14] = '{default: 0};
    ioxm_manager #(.UPDATE_CYC(UPD)) u_dut (.clk(clk), .sys_rst(sys_rst),
        .fundResetActive(fundResetActive), .linkClk(linkClk), .linkRst(linkRst),
        .eepromInitDone(eepromInitDone), .expanderEnable(expanderEnable),
        .expander_address_field_wr(addrWr), .outputView(outputView),
        .dirInputMask(dirInputMask), .shared_expander_irq_n(irqN), .jobReq_reg(jobReq),
        .jobExp_reg(jobExp), .jobRead_reg(jobRead), .jobRegNum_reg(jobRegNum),
        .jobData_reg(jobData), .jobDone(jobDone), .jobError(jobError), .jobRdData(jobRdData),
        .inputState_reg(inputState), .master_serial_status_reg(status));
    ioxm_exp_model u_model (.linkClk(linkClk), .jobReq(jobReq), .jobExp(jobExp),
        .jobRead(jobRead), .jobRegNum(jobRegNum), .jobData(jobData), .jobDone(jobDone),
        .jobError(jobError), .jobRdData(jobRdData), .delayCyc(delayCyc),
        .failNext(failNext), .pinIn(pinIn), .irqN(irqN));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // link clock, phase offset from the core clock
    initial begin
        linkClk = 1'b0;
        #7;
        forever #15 linkClk = ~linkClk;
    end
    always @(posedge linkClk) begin
        prevReq <= jobReq;
        if (jobReq && !prevReq) begin
            nJobs++;
            if (!jobRead && jobRegNum == 8'h06) nCfg[jobExp]++;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic t_config();
        repeat (200) @(posedge clk);
        fundResetActive <= 1'b0;
        repeat (200) @(posedge clk);
        `CHK(nJobs, 0)
        eepromInitDone <= 1'b1;
        `WAITC(nJobs >= 104)
        repeat (100) @(posedge clk);
        for (int e = 0; e < 14; e++) begin
            `CHK({u_model.regs[e][4], u_model.regs[e][5]}, 16'h0000)
        end
        `CHK({u_model.regs[8][6], u_model.regs[11][7]}, 16'hffff)
        `CHK(u_model.regs[12][2], outputView[199:192])
        `CHK(u_model.regs[13][3], outputView[223:216])
        `CHK({u_model.regs[12][6], u_model.regs[13][7]}, 16'h0000)
        `CHK(u_model.regs[2][6], dirInputMask[39:32])
        `CHK(inputState[143:128], 16'h5aa5)
    endtask : t_config
    task automatic t_update();
        outputView[199:192] <= 8'h3c;
        `WAITC(u_model.regs[12][2] === 8'h3c)
        `CHK(u_model.regs[12][2], 8'h3c)
        outputView[199:192] <= 8'h81;
        repeat (UPD / 2) @(posedge clk);
        `CHK(u_model.regs[12][2], 8'h3c)
        `WAITC(u_model.regs[12][2] === 8'h81)
        `CHK(u_model.regs[12][2], 8'h81)
    endtask : t_update
    task automatic t_read();
        delayCyc <= 4'hc;
        pinIn[143:128] <= 16'h00f0;
        `WAITC(inputState[143:128] === 16'h00f0)
        `CHK(inputState[143:128], 16'h00f0)
        pinIn[143:128] <= 16'h0f00;
        repeat (UPD / 4) @(posedge clk);
        `CHK(inputState[143:128], 16'h00f0)
        `WAITC(inputState[143:128] === 16'h0f00)
        `CHK(inputState[143:128], 16'h0f00)
    endtask : t_read
    task automatic t_error();
        failNext <= 1'b1;
        outputView[223:216] <= 8'h7e;
        `WAITC(status[0] === 1'b1)
        `CHK({status[2], status[0]}, 2'h3)
        failNext <= 1'b0;
    endtask : t_error
    task automatic t_reconf();
        int n0;
        n0 = nCfg[5];
        addrWr[5] <= 1'b1;
        @(posedge clk);
        addrWr[5] <= 1'b0;
        `WAITC(nCfg[5] > n0)
        `CHK(nCfg[5], n0 + 1)
    endtask : t_reconf
    task automatic t_fund();
        int n0;
        fundResetActive <= 1'b1;
        repeat (UPD) @(posedge clk);
        n0 = nJobs;
        outputView[199:192] <= 8'h55;
        repeat (UPD) @(posedge clk);
        `CHK(nJobs, n0)
        fundResetActive <= 1'b0;
        `WAITC(u_model.regs[12][2] === 8'h55)
        `CHK(u_model.regs[12][2], 8'h55)
    endtask : t_fund
    initial begin
        sys_rst = 1'b1;
        linkRst = 1'b1;
        fundResetActive = 1'b1;
        eepromInitDone = 1'b0;
        expanderEnable = 14'h3fff;
        addrWr = 14'h0000;
        outputView = {14{16'hc3a5}};
        dirInputMask = {14{16'h0f0f}};
        pinIn = {80'h0, 16'h5aa5, 128'h0};
        failNext = 1'b0;
        delayCyc = 4'h0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        linkRst <= 1'b0;
        t_config();
        t_update();
        t_error();
        t_read();
        t_reconf();
        t_fund();
        report_and_stop();
    end
endmodule : ioxm_manager_test
